//--- tb/ircg_frame_model.sv
// Behavioural companion frame timer that raises its interrupt on request
`default_nettype none
module ircg_frame_model
  import ircg_pkg::*;
#(
  parameter int IRQ_WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic fire,
  output logic frame_timer_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] hold;
  logic [7:0] next_hold;

  // Pulse spans several count clocks, as a slower frame clock would give
  always_comb begin
    next_hold = hold;
    if (fire) begin
      next_hold = 8'(IRQ_WIDTH);
    end else if (hold != 8'h00) begin
      next_hold = hold - 8'h01;
    end
  end

  // Hold counter register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hold <= 8'h00;
    end else begin
      hold <= next_hold;
    end
  end

  // Level is high only while the hold count runs
  assign frame_timer_irq = (hold != 8'h00);
endmodule
`default_nettype wire

//--- tb/test_ircg_top.sv
// Self-checking bench of the infrared carrier generator
`default_nettype none
module test_ircg_top
  import ircg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic frame_timer_irq;
  logic compare_match_irq;
  logic carrier_output_pin;
  logic fire = 1'b0;
  logic lvl;
  logic [7:0] rd;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  int run = 0;
  int k;
  int t_en;
  int irq_q[$];
  int pin_q[$];
  logic [7:0] rst_exp [7] = '{8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};

  ircg_top i_dut (
    .clk(clk),
    .rst_b(rst_b),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .frame_timer_irq(frame_timer_irq),
    .compare_match_irq(compare_match_irq),
    .carrier_output_pin(carrier_output_pin)
  );

  ircg_frame_model i_frame (
    .clk(clk),
    .rst_b(rst_b),
    .fire(fire),
    .frame_timer_irq(frame_timer_irq)
  );

  // 25 MHz clock
  initial begin
    forever #20 clk = ~clk;
  end

  // Cycle count, interrupt times, pin high run lengths and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (compare_match_irq === 1'b1) begin
      irq_q.push_back(cyc);
    end
    if (carrier_output_pin === 1'b1) begin
      run <= run + 1;
    end else begin
      if (run != 0) begin
        pin_q.push_back(run);
      end
      run <= 0;
    end
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdv(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic frame_event();
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask

  task automatic wait_irqs(input int n);
    k = 0;
    while (irq_q.size() < n && k < 2000) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask

  // Stop, reload both widths and control, then restart
  task automatic start(input logic [7:0] n, input logic [7:0] m, input ircg_ctrl_t c);
    wr(IRCG_OFF_MODE, 8'h00);
    wr(IRCG_OFF_LOW, n);
    wr(IRCG_OFF_HIGH, m);
    wr(IRCG_OFF_CTRL, {5'h00, c});
    irq_q.delete();
    pin_q.delete();
    wr(IRCG_OFF_MODE, 8'h80);
    #1;
    t_en = cyc;
  endtask

  task automatic final_report();
    if (failures == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    // Reset values, unmapped place and the read-only gate bit
    for (int a = 0; a < 7; a++) begin
      rdv(3'(a), rd);
      check("reset value", rd, rst_exp[a]);
    end
    wr(IRCG_OFF_CTRL, 8'h01);
    rdv(IRCG_OFF_CTRL, rd);
    check("active gate write", rd, 8'h00);
    wr(IRCG_OFF_CTRL, 8'h02);
    rdv(IRCG_OFF_CTRL, rd);
    check("gate buffer", rd, 8'h02);
    // Level output with remote output off
    start(8'h03, 8'h06, 3'b010);
    rdv(IRCG_OFF_STAT, rd);
    check("carrier at start", rd & 8'h01, 8'h00);
    check("pin before frame", {7'h00, carrier_output_pin}, 8'h00);
    frame_event();
    k = 0;
    while (carrier_output_pin !== 1'b1 && k < 20) begin
      @(posedge clk);
      #1;
      k++;
    end
    check("gate delay", 8'(k), 8'h05);
    rdv(IRCG_OFF_CTRL, rd);
    check("gate copied", rd, 8'h03);
    lvl = 1'b1;
    repeat (20) begin
      @(posedge clk);
      #1;
      lvl = lvl & carrier_output_pin;
    end
    check("level output", {7'h00, lvl}, 8'h01);
    wr(IRCG_OFF_CTRL, 8'h00);
    frame_event();
    repeat (6) @(posedge clk);
    #1;
    check("pin gated off", {7'h00, carrier_output_pin}, 8'h00);
    // Carrier passed and stopped by the gate, whole high widths only
    start(8'h03, 8'h02, 3'b110);
    frame_event();
    repeat (40) @(posedge clk);
    wr(IRCG_OFF_CTRL, 8'h04);
    frame_event();
    repeat (40) @(posedge clk);
    #1;
    check("pulse count", 8'(pin_q.size() >= 4), 8'h01);
    foreach (pin_q[i]) begin
      check("pin high width", 8'(pin_q[i]), 8'h03);
    end
    lvl = 1'b0;
    repeat (20) begin
      @(posedge clk);
      #1;
      lvl = lvl | carrier_output_pin;
    end
    check("pin stays low", {7'h00, lvl}, 8'h00);
    // High width rewrite early and late in a high phase
    for (int late = 0; late < 2; late++) begin
      start(8'h03, 8'h06, 3'b000);
      wait_irqs(3);
      if (late == 1) begin
        repeat (3) @(posedge clk);
      end
      wr(IRCG_OFF_HIGH, 8'h01);
      rdv(IRCG_OFF_STAT, rd);
      check("write pending", rd, (late == 1) ? 8'h04 : 8'h07);
      rdv(IRCG_OFF_HIGH, rd);
      check("latched high", rd, 8'h01);
      wait_irqs(8);
      check("low compared first", 8'(irq_q[0] - t_en <= 7), 8'h01);
      check("high phase", 8'(irq_q[1] - irq_q[0]), 8'h07);
      check("low phase", 8'(irq_q[2] - irq_q[1]), 8'h04);
      check("old high", 8'(irq_q[3] - irq_q[2]), 8'h07);
      check("next high", 8'(irq_q[5] - irq_q[4]), (late == 1) ? 8'h07 : 8'h02);
      check("new high", 8'(irq_q[7] - irq_q[6]), 8'h02);
    end
    // Stop: no matches, carrier low, frame event raises no interrupt
    wr(IRCG_OFF_MODE, 8'h00);
    wr(IRCG_OFF_CTRL, 8'h02);
    repeat (2) @(posedge clk);
    irq_q.delete();
    frame_event();
    repeat (40) @(posedge clk);
    #1;
    check("no match when stopped", 8'(irq_q.size()), 8'h00);
    check("pin when stopped", {7'h00, carrier_output_pin}, 8'h00);
    rdv(IRCG_OFF_STAT, rd);
    check("carrier when stopped", rd & 8'h01, 8'h00);
    rdv(IRCG_OFF_CTRL, rd);
    check("gate copied when stopped", rd, 8'h03);
    rdv(IRCG_OFF_CNT, rd);
    check("count when stopped", rd, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire

//--- verilog/ircg_frame_sync.sv
// Frame timer interrupt synchroniser and gate transfer strobe
`default_nettype none
module ircg_frame_sync
  import ircg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic frame_timer_irq,
  output logic synced_frame_event,
  output logic gate_transfer
);
  logic sync_1;
  logic sync_2;
  logic event_prev;
  logic xfer;
  logic rise;
  logic next_xfer;

  // Rising edge of the synchronised event, taken from the second stage only
  always_comb begin
    rise = sync_2 & ~event_prev;
    next_xfer = rise;
  end

  // Two-stage synchroniser, then one more stage so the copy lands on the second clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_1 <= 1'b0;
      sync_2 <= 1'b0;
      event_prev <= 1'b0;
      xfer <= 1'b0;
    end else begin
      sync_1 <= frame_timer_irq;
      sync_2 <= sync_1;
      event_prev <= sync_2;
      xfer <= next_xfer;
    end
  end

  assign synced_frame_event = sync_2;
  assign gate_transfer = xfer;

  chk_xfer_after_rise: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(sync_2) |=> gate_transfer ##1 !gate_transfer)
    else $error("gate transfer strobe not one cycle after event rise");
endmodule
`default_nettype wire

//--- verilog/ircg_out_gate.sv
// Output gating of the carrier onto the carrier output pin
`default_nettype none
module ircg_out_gate
  import ircg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic count_enable,
  input wire logic carrier,
  input wire logic gate_active,
  input wire logic remote_output_enable,
  output logic carrier_output_pin
);
  logic carrier_prev;
  logic pass;
  logic pin;
  logic next_pass;
  logic next_pin;

  // Pass opens only on a carrier rising edge and closes only while carrier is low or counting stops,
  // so no pulse is cut short or started midway except when the count enable is cleared
  always_comb begin
    next_pass = pass;
    if (!count_enable) begin
      next_pass = 1'b0;
    end else if (gate_active && carrier && !carrier_prev) begin
      next_pass = 1'b1;
    end else if (!gate_active && !carrier) begin
      next_pass = 1'b0;
    end
    if (!count_enable) begin
      next_pin = 1'b0;
    end else if (remote_output_enable) begin
      next_pin = next_pass & carrier;
    end else begin
      next_pin = gate_active;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      carrier_prev <= 1'b0;
      pass <= 1'b0;
      pin <= 1'b0;
    end else begin
      carrier_prev <= carrier;
      pass <= next_pass;
      pin <= next_pin;
    end
  end

  assign carrier_output_pin = pin;

  chk_pin_follows_carrier: assert property (@(posedge clk) disable iff (!rst_b)
    count_enable && remote_output_enable && !carrier |=> !carrier_output_pin)
    else $error("pin high while carrier low in remote mode");
  chk_high_width_kept: assert property (@(posedge clk) disable iff (!rst_b)
    count_enable && remote_output_enable && pass && carrier
    |=> carrier_output_pin)
    else $error("gated carrier pulse cut short");
  chk_gate_off_low: assert property (@(posedge clk) disable iff (!rst_b)
    count_enable && remote_output_enable && !gate_active && !pass
    |=> !carrier_output_pin)
    else $error("pin high with gate closed");
endmodule
`default_nettype wire

//--- verilog/ircg_pkg.sv
// Shared constants, types and register map of the infrared carrier generator
// Behaviour
// - Counting starts on the count clock when the enable bit is written to 1.
// - The first compare after enabling uses the low-width compare value.
// - Low-width match: pulse interrupt, invert carrier, clear counter, select high width.
// - High-width match: pulse interrupt, invert carrier, clear counter, select low width.
// - Carrier period is N+M+2 count clocks, high part M+1 count clocks.
// - At start the carrier stays at its default level until the first match.
// - Frame timer interrupt is synchronised into an internal frame event, not an interrupt.
// - Each frame event copies the gate buffer bit into the active gate bit.
// - While the active gate bit is high and remote output enable is 1 the carrier drives the output pin.
// - With the active gate bit low the output pin is low, except high-width protection.
// - Once gated on, the carrier reaches the pin from its next rising edge only.
// - Gated off while carrier high, the pin stays high until the carrier falls.
// - High-width writes while counting wait for a match at least three clocks later.
// - Once applied, the new high width governs all following high-width matches.
// - Clearing the enable bit stops counting.
// - Remote output enable 1 lets the gated carrier out; buffer selects per frame.
// - Remote enable 0: pin follows gate bit as a level; enable 1, gate 0: low. The pin is held low while counting is stopped.
// - Active gate bit is read-only; gate buffer bit is read/write.
// - Buffer to active copy happens on the second clock after the frame event rises.
`default_nettype none
package ircg_pkg;
  // Register offsets on the plain register port
  localparam logic [2:0] IRCG_OFF_MODE = 3'h0;
  localparam logic [2:0] IRCG_OFF_LOW = 3'h1;
  localparam logic [2:0] IRCG_OFF_HIGH = 3'h2;
  localparam logic [2:0] IRCG_OFF_CTRL = 3'h3;
  localparam logic [2:0] IRCG_OFF_STAT = 3'h4;
  localparam logic [2:0] IRCG_OFF_CNT = 3'h5;
  // Field positions
  localparam int IRCG_MODE_EN_BIT = 7;
  localparam int IRCG_CTRL_ACTIVE_BIT = 0;
  localparam int IRCG_CTRL_BUFFER_BIT = 1;
  localparam int IRCG_CTRL_REMOTE_BIT = 2;
  localparam int IRCG_STAT_CARRIER_BIT = 0;
  localparam int IRCG_STAT_SEL_BIT = 1;
  localparam int IRCG_STAT_PEND_BIT = 2;
  localparam int IRCG_STAT_PIN_BIT = 3;
  // Values after reset
  localparam logic [7:0] IRCG_RST_COMPARE = 8'hff;
  localparam logic [7:0] IRCG_RST_COUNT = 8'h00;
  localparam logic [7:0] IRCG_READ_ZERO = 8'h00;
  // Cycle counts
  localparam logic [1:0] IRCG_HIGH_SETTLE = 2'h3;
  localparam logic [7:0] IRCG_COUNT_STEP = 8'h01;
  localparam logic [1:0] IRCG_AGE_STEP = 2'h1;

  // Which compare register the counter is matched against
  typedef enum logic {
    IRCG_CMP_LOW,
    IRCG_CMP_HIGH
  } ircg_sel_t;

  // Carrier control register fields
  typedef struct packed {
    logic remote_output_enable;
    logic carrier_gate_buffer;
    logic carrier_gate_active;
  } ircg_ctrl_t;
endpackage
`default_nettype wire

//--- verilog/ircg_top.sv
// Infrared carrier generator: count logic, compare switching and registers
`default_nettype none
module ircg_top
  import ircg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic frame_timer_irq,
  output logic compare_match_irq,
  output logic carrier_output_pin
);
  // Software-visible state
  logic carrier_count_enable;
  logic [7:0] low_width_compare;
  logic [7:0] high_width_compare;
  logic [7:0] high_width_latch;
  ircg_ctrl_t carrier_control_reg;
  logic [7:0] rdata;

  // Count state
  logic started;
  logic [7:0] count;
  ircg_sel_t sel;
  logic carrier;
  logic irq;
  logic high_pending;
  logic [1:0] high_age;

  // Next values
  logic next_enable;
  logic [7:0] next_low;
  logic [7:0] next_high;
  logic [7:0] next_latch;
  ircg_ctrl_t next_ctrl;
  logic [7:0] next_rdata;
  logic next_started;
  logic [7:0] next_count;
  ircg_sel_t next_sel;
  logic next_carrier;
  logic next_irq;
  logic next_pending;
  logic [1:0] next_age;

  // Derived
  logic synced_frame_event;
  logic gate_transfer;
  logic counting;
  logic [7:0] compare_value;
  logic match;
  logic high_apply;
  logic wr_mode;
  logic wr_low;
  logic wr_high;
  logic wr_ctrl;

  // Frame event synchroniser and copy strobe
  ircg_frame_sync u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .frame_timer_irq(frame_timer_irq),
    .synced_frame_event(synced_frame_event),
    .gate_transfer(gate_transfer)
  );

  // Pin gating
  ircg_out_gate u_gate (
    .clk(clk),
    .rst_b(rst_b),
    .count_enable(carrier_count_enable),
    .carrier(carrier),
    .gate_active(carrier_control_reg.carrier_gate_active),
    .remote_output_enable(carrier_control_reg.remote_output_enable),
    .carrier_output_pin(carrier_output_pin)
  );

  // Write decode
  always_comb begin
    wr_mode = reg_wr && (reg_addr == IRCG_OFF_MODE);
    wr_low = reg_wr && (reg_addr == IRCG_OFF_LOW);
    wr_high = reg_wr && (reg_addr == IRCG_OFF_HIGH);
    wr_ctrl = reg_wr && (reg_addr == IRCG_OFF_CTRL);
  end

  // Compare selection and match; the first enabled clock is masked, not counted
  always_comb begin
    counting = carrier_count_enable && started;
    if (sel == IRCG_CMP_HIGH) begin
      compare_value = high_width_compare;
    end else begin
      compare_value = low_width_compare;
    end
    match = counting && (count == compare_value);
    high_apply = match && (sel == IRCG_CMP_HIGH) && high_pending
      && (high_age == IRCG_HIGH_SETTLE);
  end

  // Counter, compare select and carrier level
  always_comb begin
    next_started = carrier_count_enable;
    next_count = count;
    next_sel = sel;
    next_carrier = carrier;
    next_irq = 1'b0;
    if (!carrier_count_enable) begin
      next_count = IRCG_RST_COUNT;
      next_sel = IRCG_CMP_LOW;
      next_carrier = 1'b0;
    end else if (match) begin
      // Clearing on both matches gives N+1 low and M+1 high clocks
      next_count = IRCG_RST_COUNT;
      next_carrier = ~carrier;
      next_irq = 1'b1;
      if (sel == IRCG_CMP_LOW) begin
        next_sel = IRCG_CMP_HIGH;
      end else begin
        next_sel = IRCG_CMP_LOW;
      end
    end else if (counting) begin
      next_count = count + IRCG_COUNT_STEP;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      started <= 1'b0;
      count <= IRCG_RST_COUNT;
      sel <= IRCG_CMP_LOW;
      carrier <= 1'b0;
      irq <= 1'b0;
    end else begin
      started <= next_started;
      count <= next_count;
      sel <= next_sel;
      carrier <= next_carrier;
      irq <= next_irq;
    end
  end

  // Software registers; a write during counting only latches the high width,
  // a new write restarts the settle count so the freshest value is the one applied
  always_comb begin
    next_enable = carrier_count_enable;
    next_low = low_width_compare;
    next_high = high_width_compare;
    next_latch = high_width_latch;
    next_pending = high_pending;
    next_age = high_age;
    next_ctrl = carrier_control_reg;
    if (wr_mode) begin
      next_enable = reg_wdata[IRCG_MODE_EN_BIT];
    end
    if (wr_low) begin
      next_low = reg_wdata;
    end
    if (high_pending && (high_age != IRCG_HIGH_SETTLE)) begin
      next_age = high_age + IRCG_AGE_STEP;
    end
    if (high_apply) begin
      next_high = high_width_latch;
      next_pending = 1'b0;
    end
    if (!carrier_count_enable) begin
      next_pending = 1'b0;
    end
    if (wr_high) begin
      next_latch = reg_wdata;
      if (carrier_count_enable) begin
        next_pending = 1'b1;
        next_age = 2'h0;
      end else begin
        next_high = reg_wdata;
        next_pending = 1'b0;
      end
    end
    if (wr_ctrl) begin
      next_ctrl.carrier_gate_buffer = reg_wdata[IRCG_CTRL_BUFFER_BIT];
      next_ctrl.remote_output_enable = reg_wdata[IRCG_CTRL_REMOTE_BIT];
    end
    // Copy uses the buffer value held before any write in this same cycle
    if (gate_transfer) begin
      next_ctrl.carrier_gate_active = carrier_control_reg.carrier_gate_buffer;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      carrier_count_enable <= 1'b0;
      low_width_compare <= IRCG_RST_COMPARE;
      high_width_compare <= IRCG_RST_COMPARE;
      high_width_latch <= IRCG_RST_COMPARE;
      high_pending <= 1'b0;
      high_age <= 2'h0;
      carrier_control_reg <= '0;
    end else begin
      carrier_count_enable <= next_enable;
      low_width_compare <= next_low;
      high_width_compare <= next_high;
      high_width_latch <= next_latch;
      high_pending <= next_pending;
      high_age <= next_age;
      carrier_control_reg <= next_ctrl;
    end
  end

  // Read mux; data stand only in the cycle after the strobe, unmapped reads zero
  always_comb begin
    next_rdata = IRCG_READ_ZERO;
    if (reg_rd) begin
      unique case (reg_addr)
        IRCG_OFF_MODE: next_rdata[IRCG_MODE_EN_BIT] = carrier_count_enable;
        IRCG_OFF_LOW: next_rdata = low_width_compare;
        IRCG_OFF_HIGH: next_rdata = high_width_latch;
        IRCG_OFF_CTRL: begin
          next_rdata[IRCG_CTRL_ACTIVE_BIT] = carrier_control_reg.carrier_gate_active;
          next_rdata[IRCG_CTRL_BUFFER_BIT] = carrier_control_reg.carrier_gate_buffer;
          next_rdata[IRCG_CTRL_REMOTE_BIT] = carrier_control_reg.remote_output_enable;
        end
        IRCG_OFF_STAT: begin
          next_rdata[IRCG_STAT_CARRIER_BIT] = carrier;
          next_rdata[IRCG_STAT_SEL_BIT] = (sel == IRCG_CMP_HIGH);
          next_rdata[IRCG_STAT_PEND_BIT] = high_pending;
          next_rdata[IRCG_STAT_PIN_BIT] = carrier_output_pin;
        end
        IRCG_OFF_CNT: next_rdata = count;
        default: next_rdata = IRCG_READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= IRCG_READ_ZERO;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign reg_rdata = rdata;
  assign compare_match_irq = irq;

  // Checks on the count logic, the high width apply and the gate copy
  chk_match_clears_count: assert property (@(posedge clk) disable iff (!rst_b)
    match |=> (count == IRCG_RST_COUNT) && compare_match_irq)
    else $error("match did not clear counter and pulse interrupt");
  chk_match_inverts: assert property (@(posedge clk) disable iff (!rst_b)
    match && carrier_count_enable |=> carrier != $past(carrier))
    else $error("carrier not inverted on match");
  chk_low_then_high: assert property (@(posedge clk) disable iff (!rst_b)
    match && sel == IRCG_CMP_LOW |=> sel == IRCG_CMP_HIGH && carrier)
    else $error("low match did not switch to high width");
  chk_start_default: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(carrier_count_enable) |-> !carrier && sel == IRCG_CMP_LOW
    ##1 count == IRCG_RST_COUNT)
    else $error("start did not begin low with masked clock");
  chk_stop_holds: assert property (@(posedge clk) disable iff (!rst_b)
    !carrier_count_enable |=> !carrier && count == IRCG_RST_COUNT
    && !compare_match_irq)
    else $error("stopped timer still running");
  chk_early_no_apply: assert property (@(posedge clk) disable iff (!rst_b)
    match && sel == IRCG_CMP_HIGH && high_pending && high_age != IRCG_HIGH_SETTLE
    && !wr_high |=> high_width_compare == $past(high_width_compare))
    else $error("high width applied before three clocks");
  chk_late_apply: assert property (@(posedge clk) disable iff (!rst_b)
    high_apply |=> high_width_compare == $past(high_width_latch))
    else $error("latched high width not applied");
  chk_gate_copy: assert property (@(posedge clk) disable iff (!rst_b)
    gate_transfer |=> carrier_control_reg.carrier_gate_active
    == $past(carrier_control_reg.carrier_gate_buffer))
    else $error("gate buffer not copied on frame event");

  // Compare switching, stepping and the masked first clock
  chk_high_then_low: assert property (@(posedge clk) disable iff (!rst_b)
    match && sel == IRCG_CMP_HIGH |=> sel == IRCG_CMP_LOW && !carrier)
    else $error("high match did not switch to low width");
  chk_count_steps: assert property (@(posedge clk) disable iff (!rst_b)
    counting && !match |=> count == $past(count) + IRCG_COUNT_STEP)
    else $error("counter did not step by one");
  chk_first_masked: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(carrier_count_enable) ##1 carrier_count_enable |=> count == IRCG_COUNT_STEP)
    else $error("first enabled clock was counted");
  // Legal compare values are never zero, so two matches are never adjacent
  chk_irq_one_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    compare_match_irq |=> !compare_match_irq)
    else $error("compare interrupt longer than one cycle");

  // The frame event only moves the gate bit; it never raises the interrupt
  chk_irq_only_match: assert property (@(posedge clk) disable iff (!rst_b)
    !match |=> !compare_match_irq)
    else $error("interrupt without a compare match");
  chk_event_to_copy: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(synced_frame_event) |=> gate_transfer
    ##1 carrier_control_reg.carrier_gate_active
    == $past(carrier_control_reg.carrier_gate_buffer))
    else $error("gate copy not on second clock after frame event");

  // Stopping parks the count logic and the pin; a pending high width is dropped, so a restart
  // needs a fresh write of the high width
  chk_stop_sel_low: assert property (@(posedge clk) disable iff (!rst_b)
    !carrier_count_enable |=> sel == IRCG_CMP_LOW)
    else $error("stopped timer not back on low width");
  chk_stop_pending: assert property (@(posedge clk) disable iff (!rst_b)
    !carrier_count_enable |=> !high_pending)
    else $error("pending high width kept over stop");
  chk_stop_pin_low: assert property (@(posedge clk) disable iff (!rst_b)
    !carrier_count_enable |=> !carrier_output_pin)
    else $error("pin high while stopped");

  // High width writes: direct while stopped, latched and aged while counting
  chk_stopped_load: assert property (@(posedge clk) disable iff (!rst_b)
    wr_high && !carrier_count_enable |=> high_width_compare == high_width_latch
    && !high_pending)
    else $error("stopped high width write not loaded");
  chk_run_write_latched: assert property (@(posedge clk) disable iff (!rst_b)
    wr_high && carrier_count_enable && !high_apply
    |=> high_pending && high_width_compare == $past(high_width_compare))
    else $error("running high width write not latched");
  chk_age_counts: assert property (@(posedge clk) disable iff (!rst_b)
    high_pending && high_age != IRCG_HIGH_SETTLE && !wr_high
    |=> high_age == $past(high_age) + IRCG_AGE_STEP)
    else $error("high width age did not advance");
  chk_apply_clears: assert property (@(posedge clk) disable iff (!rst_b)
    high_apply && !wr_high |=> !high_pending)
    else $error("pending flag kept after apply");

  // Register port and level mode
  chk_active_read_only: assert property (@(posedge clk) disable iff (!rst_b)
    wr_ctrl && !gate_transfer |=> carrier_control_reg.carrier_gate_active
    == $past(carrier_control_reg.carrier_gate_active))
    else $error("software write changed active gate bit");
  chk_level_mode: assert property (@(posedge clk) disable iff (!rst_b)
    carrier_count_enable && !carrier_control_reg.remote_output_enable
    |=> carrier_output_pin == $past(carrier_control_reg.carrier_gate_active))
    else $error("level mode pin does not follow gate bit");
  chk_rdata_idle_zero: assert property (@(posedge clk) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == IRCG_READ_ZERO)
    else $error("read data not zero outside a read");
  chk_read_count: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd && reg_addr == IRCG_OFF_CNT |=> reg_rdata == $past(count))
    else $error("counter read returned wrong value");
  chk_read_high_latch: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd && reg_addr == IRCG_OFF_HIGH |=> reg_rdata == $past(high_width_latch))
    else $error("high width read returned wrong value");
endmodule
`default_nettype wire
